// ---- standalone_pkg.sv ----
// Constants, register map and types for standalone strap configuration
package standalone_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [7:0] OFS_GLOBAL_CONFIG  = 8'h00;
	localparam logic [7:0] OFS_CHOP_CONFIG    = 8'h04;
	localparam logic [7:0] OFS_CURRENT_CONFIG = 8'h08;
	localparam logic [7:0] OFS_MODE_STATUS    = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STATUS     = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK       = 8'h14;
	localparam logic [7:0] OFS_EFFECTIVE      = 8'h18;

	// global_config fields
	localparam int GC_FAULT_BIT = 0;
	localparam int GC_INDEX_BIT = 1;
	localparam int GC_QUIET_BIT = 2;
	localparam int GC_W         = 3;

	// chop and current config fields
	localparam int CH_OFF_TIME_LSB = 0;
	localparam int CH_USTEP_LSB    = 4;
	localparam int CUR_HOLD_LSB    = 0;
	localparam int CUR_RUN_LSB     = 8;

	// mode_status fields
	localparam int MS_STANDALONE_BIT = 0;
	localparam int MS_EXT_CLK_BIT    = 1;
	localparam int MS_SAMPLED_BIT    = 2;
	localparam int MS_STRAP_LSB      = 3;

	// effective fields
	localparam int EF_USTEP_LSB = 0;
	localparam int EF_RUN_LSB   = 4;
	localparam int EF_HOLD_LSB  = 9;
	localparam int EF_OFF_LSB   = 14;
	localparam int EF_QUIET_BIT = 18;
	localparam int EF_FAULT_BIT = 19;
	localparam int EF_INDEX_BIT = 20;

	// Power-on defaults
	localparam logic [2:0] GC_RESET       = 3'h0;
	localparam logic [3:0] OFF_TIME_RESET = 4'h0;
	localparam logic [3:0] USTEP_RESET    = 4'h0;
	localparam logic [4:0] RUN_CUR_RESET  = 5'h10;
	localparam logic [4:0] HOLD_CUR_RESET = 5'h08;

	// Standalone decode values
	localparam logic [3:0] USTEP_CODE_8   = 4'h5;
	localparam logic [4:0] RUN_CUR_BASE   = 5'h10;
	localparam logic [4:0] RUN_CUR_TOP    = 5'h1f;
	localparam logic [3:0] SA_OFF_TIME    = 4'h3;

	// Clock watchdog, in internal oscillator cycles
	localparam logic [5:0] WD_CYCLES = 6'h20;

	// Interrupt status bits
	localparam int IRQ_EXT_CLK = 0;
	localparam int IRQ_INT_CLK = 1;
	localparam int IRQ_FAULT   = 2;
	localparam int IRQ_LOADED  = 3;
	localparam int IRQ_W       = 4;

	typedef enum logic [1:0] {
		CLK_INTERNAL,
		CLK_ARMED,
		CLK_EXTERNAL
	} clk_state_t;

endpackage : standalone_pkg

// ---- strap_decode.sv ----
// Combinational decode of sampled strap levels into drive settings
`timescale 1ns/1ns
module strap_decode
	import standalone_pkg::*;
(
	input  wire logic [6:0] straps,
	output logic      [3:0] ustep_code,
	output logic      [4:0] run_cur,
	output logic            quiet_chop,
	output logic            hold_eq_run
);

	wire [2:0] cur_sel = straps[4:2];

	// Two bits select 8, 16, 32 or 64 microsteps
	assign ustep_code = USTEP_CODE_8 - {2'b00, straps[1:0]};
	// 16 + 2n, top code saturates at the full scale
	assign run_cur = (cur_sel == 3'h7) ? RUN_CUR_TOP
		: RUN_CUR_BASE + {1'b0, cur_sel, 1'b0};
	assign quiet_chop  = straps[5];
	assign hold_eq_run = ~straps[6];

endmodule : strap_decode

// ---- clk_source_select.sv ----
// Internal/external timing reference selection with edge watchdog
`timescale 1ns/1ns
module clk_source_select
	import standalone_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic ext_clk_pin,
	output logic      ext_selected,
	output logic      to_ext_pulse,
	output logic      to_int_pulse
);

	clk_state_t state_ff;
	clk_state_t nxt_state;
	logic       prev_ff;
	logic [5:0] wd_cnt_ff;
	logic [5:0] nxt_wd_cnt;
	logic       to_ext_ff;
	logic       to_int_ff;

	wire rise       = ext_clk_pin & ~prev_ff;
	wire wd_expired = wd_cnt_ff > WD_CYCLES;

	assign nxt_wd_cnt = rise ? 6'h00
		: (wd_expired ? wd_cnt_ff : wd_cnt_ff + 6'h01);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			CLK_INTERNAL: if (rise) nxt_state = CLK_ARMED;
			CLK_ARMED: begin
				if (wd_expired) nxt_state = CLK_INTERNAL;
				else if (rise) nxt_state = CLK_EXTERNAL;
			end
			CLK_EXTERNAL: if (wd_expired) nxt_state = CLK_INTERNAL;
			default: nxt_state = CLK_INTERNAL;
		endcase
	end

	// Prev starts high so a pin already high is not an edge
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff  <= CLK_INTERNAL;
			prev_ff   <= 1'b1;
			wd_cnt_ff <= 6'h00;
			to_ext_ff <= 1'b0;
			to_int_ff <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			prev_ff   <= ext_clk_pin;
			wd_cnt_ff <= nxt_wd_cnt;
			to_ext_ff <= (state_ff != CLK_EXTERNAL)
				&& (nxt_state == CLK_EXTERNAL);
			to_int_ff <= (state_ff == CLK_EXTERNAL)
				&& (nxt_state == CLK_INTERNAL);
		end
	end

	assign ext_selected = (state_ff == CLK_EXTERNAL);
	assign to_ext_pulse = to_ext_ff;
	assign to_int_pulse = to_int_ff;

	////////////////////////////////////////////////////////////////////////////
	property p_second_edge;
		@(posedge ref_clk) disable iff (!rst_n)
		(state_ff == CLK_ARMED) && rise && !wd_expired |=> ext_selected;
	endproperty
	a_second_edge: assert property (p_second_edge)
		else $error("external clock not taken on second edge");

	property p_first_edge;
		@(posedge ref_clk) disable iff (!rst_n)
		(state_ff == CLK_INTERNAL) |=> !ext_selected;
	endproperty
	a_first_edge: assert property (p_first_edge)
		else $error("external clock taken on first edge");

	property p_wd_fallback;
		@(posedge ref_clk) disable iff (!rst_n)
		ext_selected && (wd_cnt_ff == WD_CYCLES) && !rise
			|-> ##2 !ext_selected;
	endproperty
	a_wd_fallback: assert property (p_wd_fallback)
		else $error("watchdog did not fall back to internal clock");

	property p_held_low;
		@(posedge ref_clk) disable iff (!rst_n)
		(!ext_clk_pin) [*8] ##1 (wd_cnt_ff > WD_CYCLES) [*2]
			|-> !ext_selected;
	endproperty
	a_held_low: assert property (p_held_low)
		else $error("external clock kept while input held low");

	c_ext_taken: cover property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(ext_selected));

endmodule : clk_source_select

// ---- standalone_config.sv ----
// Standalone strap configuration, power-on defaults and clock selection
`timescale 1ns/1ns
// Functional notes
// - Standalone when serial select pin low and step/dir mode pin high.
// - Standalone disables both four-wire and single-wire serial interfaces.
// - Standalone forces fault-on-first-diagnostic, open-drain driver error.
// - Standalone forces index-on-second-diagnostic, open-drain index output.
// - Straps 1..0 pick microstep code 5, 4, 3 or 2.
// - Straps 4..2 give run current 16 plus 2n, or 31 at top.
// - Strap 5 low: off time 3; high: quiet chopper enabled.
// - Strap 6 low: hold current equals run current.
// - Power-on reset release loads every configuration register default.
// - Only the monitored-supply reset returns defaults; nothing else does.
// - External clock input held low keeps the internal oscillator.
// - External clock taken only on its second rising edge.
// - Watchdog returns to internal clock after 33 edgeless cycles.
module standalone_config
	import standalone_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic              serial_sel_pin,
	input  wire logic              step_dir_mode_pin,
	input  wire logic              strap_pin_0,
	input  wire logic              strap_pin_1,
	input  wire logic              strap_pin_2,
	input  wire logic              strap_pin_3,
	input  wire logic              strap_pin_4,
	input  wire logic              strap_pin_5,
	input  wire logic              strap_pin_6,
	input  wire logic              ext_clk_pin,
	input  wire logic              driver_error,
	input  wire logic              mstep_index,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_we,
	input  wire logic              reg_re,
	output logic      [DATA_W-1:0] reg_rdata,
	output logic                   standalone_active,
	output logic                   serial_if_en,
	output logic                   single_wire_en,
	output logic                   ext_clk_selected,
	output logic      [3:0]        microstep_res_code,
	output logic      [4:0]        run_current_scale,
	output logic      [4:0]        hold_current_scale,
	output logic      [3:0]        off_time_setting,
	output logic                   quiet_chop_en,
	output logic                   fault_on_first_diagnostic,
	output logic                   index_on_second_diagnostic,
	output logic                   first_diagnostic_out,
	output logic                   first_diagnostic_oe,
	output logic                   second_diagnostic_out,
	output logic                   second_diagnostic_oe,
	output logic                   irq
);

	////////////////////////////////////////////////////////////////////////////
	// Strap capture

	logic             sampled_ff;
	logic       [6:0] straps_ff;
	logic             standalone_ff;

	wire [6:0] strap_pins = {strap_pin_6, strap_pin_5, strap_pin_4,
		strap_pin_3, strap_pin_2, strap_pin_1, strap_pin_0};
	wire pins_standalone = ~serial_sel_pin & step_dir_mode_pin;

	// Levels are caught on the first edge after release, then frozen
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sampled_ff    <= 1'b0;
			straps_ff     <= 7'h00;
			standalone_ff <= 1'b0;
		end else if (!sampled_ff) begin
			sampled_ff    <= 1'b1;
			straps_ff     <= strap_pins;
			standalone_ff <= pins_standalone;
		end
	end

	logic [3:0] dec_ustep;
	logic [4:0] dec_run;
	logic       dec_quiet;
	logic       dec_hold_eq;

	strap_decode u_decode (
		.straps      (straps_ff),
		.ustep_code  (dec_ustep),
		.run_cur     (dec_run),
		.quiet_chop  (dec_quiet),
		.hold_eq_run (dec_hold_eq)
	);

	logic ext_sel;
	logic ev_to_ext;
	logic ev_to_int;

	clk_source_select u_clk (
		.ref_clk      (ref_clk),
		.rst_n        (rst_n),
		.ext_clk_pin  (ext_clk_pin),
		.ext_selected (ext_sel),
		.to_ext_pulse (ev_to_ext),
		.to_int_pulse (ev_to_int)
	);

	////////////////////////////////////////////////////////////////////////////
	// Software registers

	logic [GC_W-1:0]  gc_ff;
	logic [3:0]       off_time_ff;
	logic [3:0]       ustep_ff;
	logic [4:0]       hold_ff;
	logic [4:0]       run_ff;
	logic [IRQ_W-1:0] irq_stat_ff;
	logic [IRQ_W-1:0] irq_mask_ff;

	wire wr_gc   = reg_we && (reg_addr == OFS_GLOBAL_CONFIG);
	wire wr_chop = reg_we && (reg_addr == OFS_CHOP_CONFIG);
	wire wr_cur  = reg_we && (reg_addr == OFS_CURRENT_CONFIG);
	wire wr_stat = reg_we && (reg_addr == OFS_IRQ_STATUS);
	wire wr_mask = reg_we && (reg_addr == OFS_IRQ_MASK);

	// Only the supply-monitor reset clears these; there is no soft reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gc_ff       <= GC_RESET;
			off_time_ff <= OFF_TIME_RESET;
			ustep_ff    <= USTEP_RESET;
			hold_ff     <= HOLD_CUR_RESET;
			run_ff      <= RUN_CUR_RESET;
			irq_mask_ff <= '0;
		end else begin
			if (wr_gc)
				gc_ff <= reg_wdata[GC_W-1:0];
			if (wr_chop) begin
				off_time_ff <= reg_wdata[CH_OFF_TIME_LSB +: 4];
				ustep_ff    <= reg_wdata[CH_USTEP_LSB +: 4];
			end
			if (wr_cur) begin
				hold_ff <= reg_wdata[CUR_HOLD_LSB +: 5];
				run_ff  <= reg_wdata[CUR_RUN_LSB +: 5];
			end
			if (wr_mask)
				irq_mask_ff <= reg_wdata[IRQ_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Effective settings: straps override registers in standalone mode, except hold current with strap 6 high and off time with strap 5 high

	wire [3:0] nxt_ustep = standalone_ff ? dec_ustep : ustep_ff;
	wire [4:0] nxt_run   = standalone_ff ? dec_run : run_ff;
	wire [4:0] nxt_hold  = (standalone_ff && dec_hold_eq)
		? dec_run : hold_ff;
	wire [3:0] nxt_off   = (standalone_ff && !dec_quiet)
		? SA_OFF_TIME : off_time_ff;
	wire nxt_quiet = standalone_ff ? dec_quiet : gc_ff[GC_QUIET_BIT];
	wire nxt_fault = standalone_ff | gc_ff[GC_FAULT_BIT];
	wire nxt_index = standalone_ff | gc_ff[GC_INDEX_BIT];

	logic [3:0] ustep_eff_ff;
	logic [4:0] run_eff_ff;
	logic [4:0] hold_eff_ff;
	logic [3:0] off_eff_ff;
	logic       quiet_eff_ff;
	logic       fault_eff_ff;
	logic       index_eff_ff;
	logic       first_diagnostic_out_oe_ff;
	logic       second_diagnostic_out_oe_ff;
	logic       err_prev_ff;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ustep_eff_ff <= USTEP_RESET;
			run_eff_ff   <= RUN_CUR_RESET;
			hold_eff_ff  <= HOLD_CUR_RESET;
			off_eff_ff   <= OFF_TIME_RESET;
			quiet_eff_ff <= GC_RESET[GC_QUIET_BIT];
			fault_eff_ff <= GC_RESET[GC_FAULT_BIT];
			index_eff_ff <= GC_RESET[GC_INDEX_BIT];
			first_diagnostic_out_oe_ff  <= 1'b0;
			second_diagnostic_out_oe_ff  <= 1'b0;
			err_prev_ff  <= 1'b0;
		end else begin
			ustep_eff_ff <= nxt_ustep;
			run_eff_ff   <= nxt_run;
			hold_eff_ff  <= nxt_hold;
			off_eff_ff   <= nxt_off;
			quiet_eff_ff <= nxt_quiet;
			fault_eff_ff <= nxt_fault;
			index_eff_ff <= nxt_index;
			// Open drain: pull low only while signalling
			first_diagnostic_out_oe_ff  <= fault_eff_ff & driver_error;
			second_diagnostic_out_oe_ff  <= index_eff_ff & mstep_index;
			err_prev_ff  <= driver_error;
		end
	end

	assign microstep_res_code         = ustep_eff_ff;
	assign run_current_scale          = run_eff_ff;
	assign hold_current_scale         = hold_eff_ff;
	assign off_time_setting           = off_eff_ff;
	assign quiet_chop_en              = quiet_eff_ff;
	assign fault_on_first_diagnostic  = fault_eff_ff;
	assign index_on_second_diagnostic = index_eff_ff;
	assign first_diagnostic_out       = 1'b0;
	assign second_diagnostic_out      = 1'b0;
	assign first_diagnostic_oe        = first_diagnostic_out_oe_ff;
	assign second_diagnostic_oe       = second_diagnostic_out_oe_ff;
	assign standalone_active          = standalone_ff;
	assign serial_if_en               = ~standalone_ff;
	assign single_wire_en             = ~standalone_ff;
	assign ext_clk_selected           = ext_sel;

	////////////////////////////////////////////////////////////////////////////
	// Interrupts: sticky, write one to clear, set wins over clear

	wire [IRQ_W-1:0] irq_events;
	assign irq_events[IRQ_EXT_CLK] = ev_to_ext;
	assign irq_events[IRQ_INT_CLK] = ev_to_int;
	assign irq_events[IRQ_FAULT]   = driver_error & ~err_prev_ff;
	assign irq_events[IRQ_LOADED]  = ~sampled_ff;

	genvar gi;
	generate
		for (gi = 0; gi < IRQ_W; gi++) begin : g_irq
			wire clr = wr_stat & reg_wdata[gi];
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n)
					irq_stat_ff[gi] <= 1'b0;
				else
					irq_stat_ff[gi] <= irq_events[gi]
						| (irq_stat_ff[gi] & ~clr);
			end
		end
	endgenerate

	assign irq = |(irq_stat_ff & irq_mask_ff);

	////////////////////////////////////////////////////////////////////////////
	// Read path: data stands only in the cycle after the read strobe

	wire [DATA_W-1:0] rd_gc    = {{(DATA_W-GC_W){1'b0}}, gc_ff};
	wire [DATA_W-1:0] rd_chop  = {24'h000000, ustep_ff, off_time_ff};
	wire [DATA_W-1:0] rd_cur   = {19'h00000, run_ff, 3'h0, hold_ff};
	wire [DATA_W-1:0] rd_mode  = {22'h000000, straps_ff, sampled_ff,
		ext_sel, standalone_ff};
	wire [DATA_W-1:0] rd_stat  = {28'h0000000, irq_stat_ff};
	wire [DATA_W-1:0] rd_mask  = {28'h0000000, irq_mask_ff};
	wire [DATA_W-1:0] rd_eff   = {11'h000, index_eff_ff, fault_eff_ff,
		quiet_eff_ff, off_eff_ff, hold_eff_ff, run_eff_ff, ustep_eff_ff};

	wire [DATA_W-1:0] rd_mux =
		(reg_addr == OFS_GLOBAL_CONFIG)  ? rd_gc :
		(reg_addr == OFS_CHOP_CONFIG)    ? rd_chop :
		(reg_addr == OFS_CURRENT_CONFIG) ? rd_cur :
		(reg_addr == OFS_MODE_STATUS)    ? rd_mode :
		(reg_addr == OFS_IRQ_STATUS)     ? rd_stat :
		(reg_addr == OFS_IRQ_MASK)       ? rd_mask :
		(reg_addr == OFS_EFFECTIVE)      ? rd_eff : '0;

	logic [DATA_W-1:0] rdata_ff;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			rdata_ff <= '0;
		else
			rdata_ff <= reg_re ? rd_mux : '0;
	end

	assign reg_rdata = rdata_ff;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	wire [3:0] exp_ustep = USTEP_CODE_8 - {2'b00, straps_ff[1:0]};
	wire [4:0] exp_run   = (straps_ff[4:2] == 3'h7) ? RUN_CUR_TOP
		: RUN_CUR_BASE + {1'b0, straps_ff[4:2], 1'b0};

	property p_mode_entry;
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(sampled_ff) |->
			standalone_ff == $past(pins_standalone);
	endproperty
	a_mode_entry: assert property (p_mode_entry)
		else $error("standalone mode not taken from mode pins");

	property p_serial_off;
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(standalone_ff) |-> !serial_if_en && !single_wire_en
			##1 !serial_if_en && !single_wire_en;
	endproperty
	a_serial_off: assert property (p_serial_off)
		else $error("serial interfaces left on in standalone");

	property p_diag_forced;
		@(posedge ref_clk) disable iff (!rst_n)
		standalone_ff |=> fault_on_first_diagnostic
			&& index_on_second_diagnostic;
	endproperty
	a_diag_forced: assert property (p_diag_forced)
		else $error("diagnostic roles not forced in standalone");

	property p_first_diagnostic_out_drive;
		@(posedge ref_clk) disable iff (!rst_n)
		standalone_ff && driver_error ##1 driver_error |=>
			first_diagnostic_oe && !first_diagnostic_out;
	endproperty
	a_first_diagnostic_out_drive: assert property (p_first_diagnostic_out_drive)
		else $error("first diagnostic not pulled low on error");

	property p_ustep;
		@(posedge ref_clk) disable iff (!rst_n)
		standalone_ff |=> microstep_res_code == $past(exp_ustep);
	endproperty
	a_ustep: assert property (p_ustep)
		else $error("microstep code does not follow straps");

	property p_run_cur;
		@(posedge ref_clk) disable iff (!rst_n)
		standalone_ff |=> run_current_scale == $past(exp_run);
	endproperty
	a_run_cur: assert property (p_run_cur)
		else $error("run current does not follow straps");

	property p_chopper;
		@(posedge ref_clk) disable iff (!rst_n)
		standalone_ff && !straps_ff[5] |=>
			off_time_setting == SA_OFF_TIME && !quiet_chop_en;
	endproperty
	a_chopper: assert property (p_chopper)
		else $error("cycle chopper settings wrong");

	property p_hold;
		@(posedge ref_clk) disable iff (!rst_n)
		standalone_ff && !straps_ff[6] |=>
			hold_current_scale == run_current_scale;
	endproperty
	a_hold: assert property (p_hold)
		else $error("hold current differs from run current");

	property p_defaults;
		@(posedge ref_clk) disable iff (!rst_n)
		!sampled_ff |-> run_current_scale == RUN_CUR_RESET
			&& off_time_setting == OFF_TIME_RESET
			&& hold_current_scale == HOLD_CUR_RESET;
	endproperty
	a_defaults: assert property (p_defaults)
		else $error("defaults not loaded at reset release");

	property p_straps_frozen;
		@(posedge ref_clk) disable iff (!rst_n)
		sampled_ff |=> $stable(straps_ff) && $stable(standalone_ff);
	endproperty
	a_straps_frozen: assert property (p_straps_frozen)
		else $error("strap levels changed after capture");

	c_standalone: cover property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(standalone_ff));
	c_quiet: cover property (@(posedge ref_clk) disable iff (!rst_n)
		standalone_ff && quiet_chop_en);
	c_irq: cover property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(irq));

endmodule : standalone_config

// ---- strap_board.sv ----
// Board strap wiring and external clock source model
`timescale 1ns/1ns
module strap_board (
	input  wire logic       sa_set,
	input  wire logic [6:0] strap_set,
	input  wire logic       ext_run,
	output logic            serial_sel_pin,
	output logic            step_dir_mode_pin,
	output logic      [6:0] straps,
	output logic            ext_clk_pin
);
	// Board ties the mode pins to standalone levels when asked
	assign serial_sel_pin    = ~sa_set;
	assign step_dir_mode_pin = sa_set;
	assign straps            = strap_set;
	// No step source here, so the motor always rests
	// Period 88 ns, about 11.4 MHz; the pin stands low when stopped
	// Even half period keeps every pin edge off the rising ref_clk edge
	initial begin
		ext_clk_pin = 1'b0;
		forever begin
			#44;
			ext_clk_pin = ext_run ? ~ext_clk_pin : 1'b0;
		end
	end
endmodule : strap_board

// ---- testbench.sv ----
// Self-checking bench for standalone strap configuration
`timescale 1ns/1ns
module testbench
	import standalone_pkg::*;
;
	logic        ref_clk      = 1'b0;
	logic        rst_n        = 1'b0;
	logic        sa_set       = 1'b1;
	logic  [6:0] strap_set    = 7'h00;
	logic        ext_run      = 1'b0;
	logic        driver_error = 1'b0;
	logic        mstep_index  = 1'b0;
	logic  [7:0] reg_addr     = 8'h00;
	logic [31:0] reg_wdata    = 32'h0;
	logic        reg_we       = 1'b0;
	logic        reg_re       = 1'b0;
	logic [31:0] reg_rdata;
	logic  [6:0] straps;
	logic        serial_sel_pin, step_dir_mode_pin, ext_clk_pin;
	logic        standalone_active, serial_if_en, single_wire_en;
	logic        ext_clk_selected, quiet_chop_en, irq;
	logic  [3:0] microstep_res_code, off_time_setting;
	logic  [4:0] run_current_scale, hold_current_scale;
	logic        fault_on_first_diagnostic, index_on_second_diagnostic;
	logic        first_diagnostic_out, first_diagnostic_oe;
	logic        second_diagnostic_out, second_diagnostic_oe;
	logic [31:0] eff_port;
	int          n_mismatch = 0;
	int          n_compared = 0;

	assign eff_port = {11'h0, index_on_second_diagnostic,
		fault_on_first_diagnostic, quiet_chop_en, off_time_setting,
		hold_current_scale, run_current_scale, microstep_res_code};

	always #5 ref_clk = ~ref_clk;

	strap_board strap_board_i (.sa_set, .strap_set, .ext_run, .serial_sel_pin,
		.step_dir_mode_pin, .straps, .ext_clk_pin);

	standalone_config standalone_config_i (.ref_clk, .rst_n, .serial_sel_pin,
		.step_dir_mode_pin, .strap_pin_0(straps[0]), .strap_pin_1(straps[1]),
		.strap_pin_2(straps[2]), .strap_pin_3(straps[3]),
		.strap_pin_4(straps[4]), .strap_pin_5(straps[5]),
		.strap_pin_6(straps[6]), .ext_clk_pin, .driver_error, .mstep_index,
		.reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
		.standalone_active, .serial_if_en, .single_wire_en, .ext_clk_selected,
		.microstep_res_code, .run_current_scale, .hold_current_scale,
		.off_time_setting, .quiet_chop_en, .fault_on_first_diagnostic,
		.index_on_second_diagnostic, .first_diagnostic_out,
		.first_diagnostic_oe, .second_diagnostic_out, .second_diagnostic_oe,
		.irq);

	////////////////////////////////////////////////////////////////////////
	// Reference model of the effective settings
	function automatic logic [31:0] exp_eff(input logic sa,
		input logic [6:0] s);
		int n;
		int rn;
		int hd;
		if (!sa)
			return {11'h0, GC_RESET[1], GC_RESET[0], GC_RESET[2],
				OFF_TIME_RESET, HOLD_CUR_RESET, RUN_CUR_RESET, USTEP_RESET};
		n = s[4:2];
		rn = (n == 7) ? 31 : 16 + 2 * n;
		hd = s[6] ? int'(HOLD_CUR_RESET) : rn;
		return {11'h0, 1'b1, 1'b1, s[5], s[5] ? OFF_TIME_RESET : 4'h3,
			5'(hd), 5'(rn), 4'(5 - s[1:0])};
	endfunction : exp_eff

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_we <= 1'b0;
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_re <= 1'b0;
		#1 check(reg_rdata, exp);
	endtask : rdc

	task automatic boot(input logic sa, input logic [6:0] s);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		sa_set <= sa;
		strap_set <= s;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask : boot

	task automatic check_all(input logic sa, input logic [6:0] s);
		check(eff_port, exp_eff(sa, s));
		check({28'h0, serial_if_en, single_wire_en, standalone_active,
			ext_clk_selected}, {28'h0, ~sa, ~sa, sa, 1'b0});
		rdc(OFS_EFFECTIVE, exp_eff(sa, s));
		rdc(OFS_MODE_STATUS, {22'h0, s, 1'b1, 1'b0, sa});
	endtask : check_all

	task automatic summarize;
		if (n_mismatch == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize

	////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		n_mismatch++;
		summarize();
	end

	initial begin
		logic [6:0] s;
		void'($urandom(32'hc3ce));
		for (int i = 0; i < 8; i++) begin
			s = {2'($urandom()), 3'(i), 2'(i)};
			boot(1'b1, s);
			check_all(1'b1, s);
		end
		// Outside standalone the register defaults drive the outputs
		s = 7'($urandom());
		boot(1'b0, s);
		check_all(1'b0, s);
		rdc(OFS_IRQ_STATUS, 32'h8);
		rdc(OFS_IRQ_MASK, 32'h0);
		wr(OFS_IRQ_MASK, 32'h8);
		#1 check({31'h0, irq}, 32'h1);
		wr(OFS_IRQ_STATUS, 32'h8);
		#1 check({31'h0, irq}, 32'h0);
		wr(OFS_CURRENT_CONFIG, 32'h00001a0c);
		repeat (2) @(posedge ref_clk);
		#1 check({22'h0, run_current_scale, hold_current_scale},
			{22'h0, 5'h1a, 5'h0c});
		rdc(OFS_CURRENT_CONFIG, 32'h00001a0c);
		wr(OFS_CHOP_CONFIG, 32'h000000a7);
		wr(OFS_GLOBAL_CONFIG, 32'h00000005);
		repeat (2) @(posedge ref_clk);
		#1 check({24'h0, microstep_res_code, off_time_setting},
			32'ha7);
		check({29'h0, quiet_chop_en, index_on_second_diagnostic,
			fault_on_first_diagnostic}, 32'h5);
		rdc(OFS_CHOP_CONFIG, 32'h000000a7);
		rdc(OFS_GLOBAL_CONFIG, 32'h00000005);
		rdc(8'h40, 32'h0);
		wr(OFS_MODE_STATUS, 32'hffffffff);
		rdc(OFS_MODE_STATUS, {22'h0, s, 3'b100});
		boot(1'b0, s);
		check_all(1'b0, s);
		// Standalone: later strap changes and register writes are ignored
		s = {1'b0, 6'($urandom())};
		boot(1'b1, s);
		@(posedge ref_clk);
		strap_set <= ~s;
		wr(OFS_CURRENT_CONFIG, 32'h00000101);
		wr(OFS_GLOBAL_CONFIG, 32'h0);
		repeat (2) @(posedge ref_clk);
		#1 check_all(1'b1, s);
		@(posedge ref_clk);
		driver_error <= 1'b1;
		mstep_index <= 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 check({28'h0, first_diagnostic_oe, first_diagnostic_out,
			second_diagnostic_oe, second_diagnostic_out}, 32'ha);
		@(posedge ref_clk);
		driver_error <= 1'b0;
		mstep_index <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1 check({30'h0, first_diagnostic_oe, second_diagnostic_oe},
			32'h0);
		rdc(OFS_IRQ_STATUS, 32'hc);
		wr(OFS_IRQ_MASK, 32'h4);
		#1 check({31'h0, irq}, 32'h1);
		wr(OFS_IRQ_STATUS, 32'h4);
		#1 check({31'h0, irq}, 32'h0);
		// External clock: armed by the first rise, taken on the second
		@(posedge ref_clk);
		ext_run <= 1'b1;
		@(posedge ext_clk_pin);
		repeat (4) @(posedge ref_clk);
		#1 check({31'h0, ext_clk_selected}, 32'h0);
		@(posedge ext_clk_pin);
		repeat (3) @(posedge ref_clk);
		#1 check({31'h0, ext_clk_selected}, 32'h1);
		repeat (40) @(posedge ref_clk);
		#1 check({31'h0, ext_clk_selected}, 32'h1);
		@(posedge ref_clk);
		ext_run <= 1'b0;
		repeat (45) @(posedge ref_clk);
		#1 check({31'h0, ext_clk_selected}, 32'h0);
		rdc(OFS_IRQ_STATUS, 32'hb);
		summarize();
	end
endmodule : testbench
